// file: pkg/slot_power_regs.svh
`ifndef SLOT_POWER_REGS_SVH
`define SLOT_POWER_REGS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CTRL 12'h000
`define ADDR_COMMON 12'h004
`define ADDR_SLOT_A 12'h008
`define ADDR_SLOT_B 12'h00c
`define ADDR_IRQ_STATUS 12'h010
`define ADDR_IRQ_ENABLE 12'h014
`define ADDR_IRQ_CLEAR 12'h018
`define ADDR_FILTER_A 12'h01c
`define ADDR_FILTER_B 12'h020
// ----------------------------------------
// field positions
// ----------------------------------------
// ctrl: per slot main on bit 0/2, aux on bit 1/3
`define CTRL_MAIN_A 0
`define CTRL_AUX_A 1
`define CTRL_MAIN_B 2
`define CTRL_AUX_B 3
// common: fault a 0, fault b 1, mask 3, gpi 4..5, straps 6..7
`define CS_FAULT_A 0
`define CS_FAULT_B 1
`define CS_MASK 3
`define CS_GPI_A 4
`define CS_GPI_B 5
`define CS_STRAP_LO 6
`define CS_STRAP_HI 7
// slot status: main fault 0, aux fault 1, main on 2, aux on 3
`define ST_MAIN_FLT 0
`define ST_AUX_FLT 1
`define ST_MAIN_ON 2
`define ST_AUX_ON 3
// irq status, enable and clear: main a 0, aux a 1, main b 2, aux b 3
`define IRQ_MAIN_A 0
`define IRQ_AUX_A 1
`define IRQ_MAIN_B 2
`define IRQ_AUX_B 3
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define FILTER_RESET 16'h01f4
`define CS_MASK_RESET 1'b0
`define IRQ_EN_RESET 4'hf
`endif

// file: pkg/slot_power_pkg.sv
package slot_power_pkg;
    typedef logic [15:0] filter_count_type;
endpackage

// file: logic/dual_slot_power_fault_logic.sv
`timescale 1ns/100ps
`include "slot_power_regs.svh"
// Contract
// RL1: rising edge of main enable switches slot main outputs on.
// RL2: main enable low after fault clears main fault latches.
// RL3: rising edge of aux enable switches slot aux output on.
// RL4: aux enable low after fault clears aux fault latch.
// RL5: with bus power control, system ties both enable pins low.
// RL6: breaker trips only after current limit lasts the filter period.
// RL7: fault output asserted whenever slot breaker trips.
// RL8: main-caused fault output released by main enable low.
// RL9: aux-caused fault output released by aux enable low.
// RL10: both faults need both enables low to release fault output.
// RL11: general purpose inputs read as common status bits 4 and 5.
// RL12: bus base address comes from two strap inputs, open is high.
// RL13: interrupt output asserted on power fault when mask bit is zero.
// RL14: host writes back set fault bits to release interrupt.
// RL15: gate drive pulled low at once on any slot fault; main_gate_on drops on a main trip only, not on an aux fault.
// RL16: writing one to a set fault bit clears it; zero no change.
module dual_slot_power_fault_logic (
    input wire logic pclk, // 50 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [1:0] main_enable_input, // main enable per slot
    input wire logic [1:0] aux_power_enable_input, // aux enable per slot
    input wire logic [1:0] current_limit, // slot in current limit
    input wire logic [1:0] main_hard_fault, // main uv or overtemp
    input wire logic [1:0] aux_current_limit, // aux in current limit
    input wire logic [1:0] aux_hard_fault, // aux short or overtemp
    input wire logic [1:0] general_purpose_input, // gpi levels
    input wire logic address_strap_high, // strap, high when open
    input wire logic address_strap_low, // strap, high when open
    output logic [1:0] main_gate_on, // main gate drive per slot
    output logic [1:0] aux_supply_output, // aux switch on per slot
    output logic [1:0] fault_out_o, // fault pin out, always 0
    output logic [1:0] fault_oe_n, // fault pin enable, low drives
    output logic int_out_o, // interrupt pin out, always 0
    output logic int_oe_n, // interrupt pin enable, low drives
    output logic [1:0] bus_address // strap-derived base address
);
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    logic wr_en;
    logic rd_en;
    logic [3:0] ctrl_q;
    logic mask_q;
    logic [3:0] irq_en_q;
    slot_power_pkg::filter_count_type filter_q [2];
    // each bit is driven by its own slot channel, hence nets
    wire logic [1:0] main_flt_q;
    wire logic [1:0] aux_flt_q;
    wire logic [1:0] main_on_q;
    wire logic [1:0] aux_on_q;
    logic [1:0] main_clr;
    logic [1:0] aux_clr;
    logic [3:0] irq_status;
    logic [31:0] rd_d;
    logic known;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        known = 1'b1;
        rd_d = 32'h0000_0000;
        unique case (paddr)
            `ADDR_CTRL: rd_d[3:0] = ctrl_q;
            // gpi levels and straps readable
            // RL11: gpi status bits
            `ADDR_COMMON: begin
                rd_d[`CS_FAULT_A] = main_flt_q[0] | aux_flt_q[0];
                rd_d[`CS_FAULT_B] = main_flt_q[1] | aux_flt_q[1];
                rd_d[`CS_MASK] = mask_q;
                rd_d[`CS_GPI_A] = general_purpose_input[0];
                rd_d[`CS_GPI_B] = general_purpose_input[1];
                rd_d[`CS_STRAP_LO] = address_strap_low;
                rd_d[`CS_STRAP_HI] = address_strap_high;
            end
            `ADDR_SLOT_A: begin
                rd_d[`ST_MAIN_FLT] = main_flt_q[0];
                rd_d[`ST_AUX_FLT] = aux_flt_q[0];
                rd_d[`ST_MAIN_ON] = main_on_q[0];
                rd_d[`ST_AUX_ON] = aux_on_q[0];
            end
            `ADDR_SLOT_B: begin
                rd_d[`ST_MAIN_FLT] = main_flt_q[1];
                rd_d[`ST_AUX_FLT] = aux_flt_q[1];
                rd_d[`ST_MAIN_ON] = main_on_q[1];
                rd_d[`ST_AUX_ON] = aux_on_q[1];
            end
            `ADDR_IRQ_STATUS: rd_d[3:0] = irq_status;
            `ADDR_IRQ_ENABLE: rd_d[3:0] = irq_en_q;
            `ADDR_IRQ_CLEAR: rd_d = 32'h0000_0000;
            `ADDR_FILTER_A: rd_d[15:0] = filter_q[0];
            `ADDR_FILTER_B: rd_d[15:0] = filter_q[1];
            default: known = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !known;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rd_d;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 4'h0;
            mask_q <= `CS_MASK_RESET;
            irq_en_q <= `IRQ_EN_RESET;
            filter_q[0] <= `FILTER_RESET;
            filter_q[1] <= `FILTER_RESET;
        end else if (wr_en) begin
            unique case (paddr)
                `ADDR_CTRL: ctrl_q <= pwdata[3:0];
                `ADDR_COMMON: mask_q <= pwdata[`CS_MASK];
                `ADDR_IRQ_ENABLE: irq_en_q <= pwdata[3:0];
                `ADDR_FILTER_A: filter_q[0] <= pwdata[15:0];
                `ADDR_FILTER_B: filter_q[1] <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // fault clear strobes
    // ----------------------------------------
    // two ways to clear: echo on the slot status or the irq clear word
    // RL16: write one clears
    always_comb begin
        main_clr = 2'b00;
        aux_clr = 2'b00;
        if (wr_en && paddr == `ADDR_SLOT_A) begin
            main_clr[0] = pwdata[`ST_MAIN_FLT];
            aux_clr[0] = pwdata[`ST_AUX_FLT];
        end
        if (wr_en && paddr == `ADDR_SLOT_B) begin
            main_clr[1] = pwdata[`ST_MAIN_FLT];
            aux_clr[1] = pwdata[`ST_AUX_FLT];
        end
        if (wr_en && paddr == `ADDR_IRQ_CLEAR) begin
            main_clr = {pwdata[`IRQ_MAIN_B], pwdata[`IRQ_MAIN_A]};
            aux_clr = {pwdata[`IRQ_AUX_B], pwdata[`IRQ_AUX_A]};
        end
    end

    // ----------------------------------------
    // per-slot channels
    // ----------------------------------------
    // slots share only the bus, so a fault on one never touches the other
    slot_power_channel i_slot_a (
        .pclk(pclk),
        .presetn(presetn),
        .main_pin(main_enable_input[0]),
        .aux_pin(aux_power_enable_input[0]),
        .main_ctrl(ctrl_q[`CTRL_MAIN_A]),
        .aux_ctrl(ctrl_q[`CTRL_AUX_A]),
        .current_limit(current_limit[0]),
        .main_hard_fault(main_hard_fault[0]),
        .aux_current_limit(aux_current_limit[0]),
        .aux_hard_fault(aux_hard_fault[0]),
        .filter(filter_q[0]),
        .main_clr(main_clr[0]),
        .aux_clr(aux_clr[0]),
        .main_on_q(main_on_q[0]),
        .aux_on_q(aux_on_q[0]),
        .main_flt_q(main_flt_q[0]),
        .aux_flt_q(aux_flt_q[0])
    );

    slot_power_channel i_slot_b (
        .pclk(pclk),
        .presetn(presetn),
        .main_pin(main_enable_input[1]),
        .aux_pin(aux_power_enable_input[1]),
        .main_ctrl(ctrl_q[`CTRL_MAIN_B]),
        .aux_ctrl(ctrl_q[`CTRL_AUX_B]),
        .current_limit(current_limit[1]),
        .main_hard_fault(main_hard_fault[1]),
        .aux_current_limit(aux_current_limit[1]),
        .aux_hard_fault(aux_hard_fault[1]),
        .filter(filter_q[1]),
        .main_clr(main_clr[1]),
        .aux_clr(aux_clr[1]),
        .main_on_q(main_on_q[1]),
        .aux_on_q(aux_on_q[1]),
        .main_flt_q(main_flt_q[1]),
        .aux_flt_q(aux_flt_q[1])
    );

    assign main_gate_on = main_on_q;
    assign aux_supply_output = aux_on_q;

    // ----------------------------------------
    // fault and interrupt pins
    // ----------------------------------------
    // RL7: fault pin follows latches
    // RL8: main release
    // RL9: aux release
    // RL10: both must clear
    assign fault_oe_n = ~(main_flt_q | aux_flt_q);
    assign fault_out_o = 2'b00;

    assign irq_status = {aux_flt_q[1], main_flt_q[1],
                         aux_flt_q[0], main_flt_q[0]};
    // RL13: masked interrupt
    // RL14: released by echo reset
    assign int_oe_n = !(!mask_q && |(irq_status & irq_en_q));
    assign int_out_o = 1'b0;

    // RL12: strap address
    assign bus_address = {address_strap_high, address_strap_low};

endmodule // dual_slot_power_fault_logic

// ----------------------------------------
// one slot: enable edges, filter timer, fault latches
// ----------------------------------------
module slot_power_channel (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic main_pin, // main enable pin
    input wire logic aux_pin, // aux enable pin
    input wire logic main_ctrl, // main enable control bit
    input wire logic aux_ctrl, // aux enable control bit
    input wire logic current_limit, // main in current limit
    input wire logic main_hard_fault, // main uv or overtemp
    input wire logic aux_current_limit, // aux in current limit
    input wire logic aux_hard_fault, // aux short or overtemp
    input wire logic [15:0] filter, // trip count
    input wire logic main_clr, // write one clear, main latch
    input wire logic aux_clr, // write one clear, aux latch
    output logic main_on_q, // main gate drive
    output logic aux_on_q, // aux switch drive
    output logic main_flt_q, // main fault latch
    output logic aux_flt_q // aux fault latch
);
    logic main_en;
    logic aux_en;
    logic main_en_q;
    logic aux_en_q;
    logic [15:0] count_q;
    logic main_trip;
    logic aux_trip;

    // pins and control bits are ored; a pin tied low leaves bus control
    assign main_en = main_pin | main_ctrl;
    assign aux_en = aux_pin | aux_ctrl;

    // RL5: tied-low pins hand over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_en_q <= 1'b0;
            aux_en_q <= 1'b0;
        end else begin
            main_en_q <= main_en;
            aux_en_q <= aux_en;
        end
    end

    // RL6: filtered breaker trip
    // counter saturates so a long limit cannot wrap past the trip point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 16'h0000;
        end else if (!current_limit || !main_on_q) begin
            count_q <= 16'h0000;
        end else if (count_q != filter) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign main_trip = main_on_q && (main_hard_fault ||
        (current_limit && count_q == filter));
    // aux has no filter: its limit trips at once
    assign aux_trip = aux_on_q && (aux_hard_fault || aux_current_limit);

    // RL1: main on rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_on_q <= 1'b0;
        end else if (main_trip || !main_en) begin
            // RL15: gate low on fault
            main_on_q <= 1'b0;
        end else if (main_en && !main_en_q && !main_flt_q) begin
            main_on_q <= 1'b1;
        end
    end

    // RL3: aux on rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_on_q <= 1'b0;
        end else if (aux_trip || !aux_en) begin
            aux_on_q <= 1'b0;
        end else if (aux_en && !aux_en_q && !aux_flt_q) begin
            aux_on_q <= 1'b1;
        end
    end

    // RL2: main latch cleared by enable low; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_flt_q <= 1'b0;
        end else if (main_trip) begin
            main_flt_q <= 1'b1;
        end else if (!main_en || main_clr) begin
            main_flt_q <= 1'b0;
        end
    end

    // RL4: aux latch cleared by enable low; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_flt_q <= 1'b0;
        end else if (aux_trip) begin
            aux_flt_q <= 1'b1;
        end else if (!aux_en || aux_clr) begin
            aux_flt_q <= 1'b0;
        end
    end

endmodule // slot_power_channel

// file: test/slot_checker_assertions.sv
`timescale 1ns/100ps
`include "slot_power_regs.svh"
module slot_checker (
    input wire logic pclk, presetn, psel, penable, pwrite, // apb
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, prdata, // data
    input wire logic [1:0] main_enable_input, current_limit, // slot in
    input wire logic [1:0] main_hard_fault, aux_hard_fault, // faults
    input wire logic [1:0] aux_current_limit, general_purpose_input, // in
    input wire logic address_strap_high, address_strap_low, int_oe_n, // pins
    input wire logic [1:0] main_gate_on, fault_oe_n, bus_address // out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [1:0] hard;
    // limit left out: it only trips once the filter runs out
    assign hard = main_hard_fault | aux_hard_fault | aux_current_limit;
    property p_main_on;
        $rose(main_enable_input[0]) && fault_oe_n[0] && !hard[0]
            && !current_limit[0] |-> ##[1:3] main_gate_on[0];
    endproperty
    a_main_on: assert property (p_main_on) else $error("no turn on");
    property p_filter;
        $rose(current_limit[0]) && fault_oe_n[0] && !hard[0]
            && !$past(hard[0]) |=> fault_oe_n[0];
    endproperty
    a_filter: assert property (p_filter) else $error("early trip");
    property p_fault_pin;
        main_hard_fault[1] && main_gate_on[1] |-> ##[1:2] !fault_oe_n[1];
    endproperty
    a_fault_pin: assert property (p_fault_pin) else $error("no fault");
    property p_gate_off;
        main_hard_fault[1] && main_gate_on[1] |-> ##[1:2] !main_gate_on[1];
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate on");
    property p_irq;
        !int_oe_n |-> fault_oe_n != 2'h3;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without fault");
    property p_echo;
        psel && penable && pwrite && paddr == `ADDR_SLOT_B
            && pwdata[1:0] == 2'h3 && fault_oe_n[0] && !hard[1]
            && !$past(hard[1]) && !current_limit[1] |=> int_oe_n;
    endproperty
    a_echo: assert property (p_echo) else $error("irq kept");
    property p_inputs;
        psel && !penable && !pwrite && paddr == `ADDR_COMMON
            |=> prdata[5:4] == $past(general_purpose_input);
    endproperty
    a_inputs: assert property (p_inputs) else $error("input bits");
    property p_strap;
        bus_address == {address_strap_high, address_strap_low};
    endproperty
    a_strap: assert property (p_strap) else $error("address wrong");
endmodule // slot_checker
bind dual_slot_power_fault_logic slot_checker i_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .main_enable_input,
    .current_limit, .main_hard_fault, .aux_hard_fault, .aux_current_limit,
    .general_purpose_input, .address_strap_high, .address_strap_low,
    .int_oe_n, .main_gate_on, .fault_oe_n, .bus_address);

// file: test/slot_host.sv
`timescale 1ns/100ps
module slot_host (
    input wire logic pclk, // clock
    output logic [1:0] main_en, // main enable pins
    output logic [1:0] aux_en, // aux enable pins
    output logic [7:0] faults // aux limit, aux hard, main hard, limit
);
    logic [4:0] en_q = 5'h00;
    initial faults = 8'h00;
    assign main_en = en_q[4] ? 2'h0 : en_q[1:0];
    assign aux_en = en_q[4] ? 2'h0 : en_q[3:2];
    // bus mode, aux, main; returns n edges later, settled
    task automatic drive(input logic [4:0] e, input logic [7:0] v,
            input int n);
        @(posedge pclk);
        en_q <= e;
        faults <= v;
        repeat (n) @(posedge pclk);
        #1;
    endtask
endmodule // slot_host

// file: test/testbench.sv
`timescale 1ns/100ps
`include "slot_power_regs.svh"
module testbench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, address_strap_high = 1'b1, address_strap_low = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [1:0] general_purpose_input = 2'h2, main_gate_on, fault_oe_n;
    logic [1:0] main_enable_input, aux_power_enable_input, bus_address;
    logic [1:0] aux_supply_output, fault_out_o;
    logic pready, pslverr, err, int_out_o, int_oe_n;
    logic [7:0] f;
    int fails = 0, n_compared = 0;
    always #10 pclk = ~pclk;
    slot_host i_slot_host (.pclk, .main_en(main_enable_input),
        .aux_en(aux_power_enable_input), .faults(f));
    dual_slot_power_fault_logic i_dual_slot_power_fault_logic (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .main_enable_input, .aux_power_enable_input,
        .current_limit(f[1:0]), .main_hard_fault(f[3:2]),
        .aux_hard_fault(f[5:4]), .aux_current_limit(f[7:6]),
        .general_purpose_input, .address_strap_high, .address_strap_low,
        .main_gate_on, .aux_supply_output, .fault_out_o, .fault_oe_n,
        .int_out_o, .int_oe_n, .bus_address);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // read data and error are taken at the access edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        fails += int'(n == 20);
        if (n == 20) complete_run();
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ADDR_FILTER_B, 32'h0);
        check(rd, 32'h000001f4);
        apb(1'b1, `ADDR_FILTER_A, 32'h4);
        apb(1'b0, `ADDR_COMMON, 32'h0);
        check({rd[7:4], bus_address}, 6'h2a);
        apb(1'b0, 12'h024, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        i_slot_host.drive(5'h07, 8'h00, 4);
        check({aux_supply_output, main_gate_on}, 4'h7);
        // limit shorter than the filter, then longer
        i_slot_host.drive(5'h07, 8'h01, 2);
        i_slot_host.drive(5'h07, 8'h00, 2);
        check(fault_oe_n, 2'h3);
        i_slot_host.drive(5'h07, 8'h01, 8);
        check({int_oe_n, main_gate_on, fault_oe_n}, 5'h0a);
        i_slot_host.drive(5'h07, 8'h10, 2);
        i_slot_host.drive(5'h06, 8'h00, 3);
        check(fault_oe_n, 2'h2);
        apb(1'b0, `ADDR_SLOT_A, 32'h0);
        check(rd[1:0], 2'h2);
        i_slot_host.drive(5'h02, 8'h00, 3);
        check(fault_oe_n, 2'h3);
        // masked fault on slot b, unmask, then echo reset
        apb(1'b1, `ADDR_COMMON, 32'h8);
        i_slot_host.drive(5'h02, 8'h08, 2);
        i_slot_host.drive(5'h02, 8'h00, 1);
        check({int_oe_n, fault_oe_n}, 3'h5);
        apb(1'b1, `ADDR_COMMON, 32'h0);
        apb(1'b1, `ADDR_SLOT_B, 32'h0);
        apb(1'b0, `ADDR_SLOT_B, 32'h0);
        check({int_oe_n, rd[0]}, 2'h1);
        apb(1'b1, `ADDR_SLOT_B, 32'h3);
        apb(1'b0, `ADDR_SLOT_B, 32'h0);
        check({int_oe_n, fault_oe_n, rd[0]}, 4'he);
        i_slot_host.drive(5'h12, 8'h00, 3);
        check(main_gate_on, 2'h0);
        apb(1'b1, `ADDR_CTRL, 32'h1);
        apb(1'b0, `ADDR_CTRL, 32'h0);
        check(main_gate_on, 2'h1);
        // slot a main fault under bus control, cleared by irq clear word
        i_slot_host.drive(5'h12, 8'h04, 2);
        i_slot_host.drive(5'h12, 8'h00, 1);
        apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
        check({int_oe_n, main_gate_on, rd[3:0]}, 7'h01);
        apb(1'b1, `ADDR_IRQ_CLEAR, 32'h1);
        apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
        check({int_oe_n, fault_oe_n, rd[3:0]}, 7'h70);
        check({fault_out_o, int_out_o, pready, pslverr}, 5'h02);
        complete_run();
    end
endmodule // testbench
